// *** uart_ctl_pkg.sv ***
//
// Behaviour
// [R01] Each of four interrupt sources is gated by its own enable bit
// [R02] Ident read clears tx-empty; toggling its enable re-raises it
// [R03] Software checks for a spurious tx-empty when clearing its enable
// [R04] Divisor banked pair needs the access bit; direct pair always works
// [R05] Divisor is sixteen bits, high byte and low byte, value 1 to 65535
// [R06] Generator divides the selected clock by the divisor, giving 16x rate
// [R07] Source field picks system clock or timebase divided by 2, 4, 8
// [R08] Software loads the divisor at initialisation; reset value undefined
// [R09] Line status request on an error in the first byte; line read clears
// [R10] Received-data request at trigger level; clears when count drops below
// [R11] Timeout when data waits unread four frame times, in baud clocks
// [R12] FIFO read clears timeout and restarts timer; arrival restarts if idle
// [R13] Tx-empty request when tx FIFO empty; holding write or ident read clears
// [R14] Tx-empty delayed one frame less a stop bit when under two bytes; code delays after every drain, at any count
// [R15] Enables all zero stops trigger and timeout requests; buffering goes on
// [R16] Mode 0 tx DMA request while tx empty, dropped at first write
// [R17] Mode 1 tx DMA request from empty until tx buffer is full
// [R18] Mode 0 rx DMA request while the receive buffer holds data
// [R19] Mode 1 rx DMA request at trigger or timeout, until rx empty
// [R20] Ident reports line, then rx data or timeout, then tx, then modem
// [R21] One interrupt output, active when any enabled source is pending
package uart_ctl_pkg;
  localparam logic [23:0] OFS_DIV_LOW_BANKED  = 24'h600300;
  localparam logic [23:0] OFS_DIV_HIGH_BANKED = 24'h600304;
  localparam logic [23:0] OFS_DIV_LOW_DIRECT  = 24'h600320;
  localparam logic [23:0] OFS_DIV_HIGH_DIRECT = 24'h600324;
  localparam logic [23:0] OFS_IRQ_ENABLES     = 24'h600308;
  localparam logic [23:0] OFS_IDENT           = 24'h60030C;
  localparam logic [23:0] OFS_CLOCK_SELECT    = 24'h600310;
  localparam logic [7:0]  RST_IRQ_ENABLES     = 8'h00;
  localparam logic [7:0]  RST_CLOCK_SELECT    = 8'h00;
  localparam logic [15:0] RST_DIVISOR         = 16'h0001;
  localparam int          BIT_RX_DATA_EN      = 0;
  localparam int          BIT_TX_EMPTY_EN     = 1;
  localparam int          BIT_LINE_EN         = 2;
  localparam int          BIT_MODEM_EN        = 3;
  localparam logic [3:0]  ID_NONE             = 4'h1;
  localparam logic [3:0]  ID_LINE             = 4'h6;
  localparam logic [3:0]  ID_RX_DATA          = 4'h4;
  localparam logic [3:0]  ID_TIMEOUT          = 4'hC;
  localparam logic [3:0]  ID_TX_EMPTY         = 4'h2;
  localparam logic [3:0]  ID_MODEM            = 4'h0;
  localparam logic [1:0]  FIFO_ON_BITS        = 2'h3;
  // Baud clocks per bit, and the timeout in frames (four frames of frame_len bits)
  localparam logic [4:0]  BAUD_PER_BIT        = 5'h10;
  localparam int          FRAMES_TIMEOUT      = 4;
endpackage : uart_ctl_pkg

// *** uart_irq_baud_dma_control.sv ***
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module uart_irq_baud_dma_control #(
  parameter int FIFO_DEPTH = 16,
  parameter int CW         = 5
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Avalon-MM slave
  input  wire logic [23:0]   avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  // Surrounding UART state
  input  wire logic          timebase_clock_i,
  input  wire logic          divisor_access_bit_i,
  input  wire logic          dma_mode_select_i,
  input  wire logic          fifo_enabled_i,
  input  wire logic          two_stop_bits_i,
  input  wire logic [3:0]    frame_bits_i,
  input  wire logic [CW-1:0] rx_count_i,
  input  wire logic [CW-1:0] rx_trigger_i,
  input  wire logic          rx_push_i,
  input  wire logic          rx_pop_i,
  input  wire logic          rx_first_error_i,
  input  wire logic          line_state_read_i,
  input  wire logic [CW-1:0] tx_count_i,
  input  wire logic          tx_holding_write_i,
  input  wire logic          modem_delta_i,
  // Outputs
  output logic               baud_tick_o,
  output logic               serial_irq_out_o,
  output logic               tx_dma_request_o,
  output logic               rx_dma_request_o
);
  localparam logic [CW-1:0] FULL_COUNT = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] ZERO_COUNT = '0;
  localparam logic [CW-1:0] TWO_COUNT  = CW'(2);

  // Register state
  logic [7:0]  irq_enables;
  logic [1:0]  baud_source_field;
  logic [15:0] divisor;
  logic        rsp_valid;
  logic [31:0] rd_data;

  // Timebase is off-domain: two flops before use
  logic        tb_meta;
  logic        tb_sync;
  logic        tb_prev;
  logic [2:0]  tb_div;
  logic        src_tick;
  logic [15:0] baud_cnt;
  logic [3:0]  bit_phase;
  logic        bit_tick;

  // Interrupt state
  logic        tx_empty_pend;
  logic        tx_empty_seen;
  logic [7:0]  tx_delay_cnt;
  logic        timeout_pend;
  logic [7:0]  idle_bits;
  logic [3:0]  ident_id;

  // Address decode
  wire logic hit_low_b  = (avs_address_i == uart_ctl_pkg::OFS_DIV_LOW_BANKED)
                          && divisor_access_bit_i;  // [R04]
  wire logic hit_high_b = (avs_address_i == uart_ctl_pkg::OFS_DIV_HIGH_BANKED)
                          && divisor_access_bit_i;  // [R04]
  wire logic hit_low_d  = avs_address_i == uart_ctl_pkg::OFS_DIV_LOW_DIRECT;
  wire logic hit_high_d = avs_address_i == uart_ctl_pkg::OFS_DIV_HIGH_DIRECT;
  wire logic hit_low    = hit_low_b || hit_low_d;   // [R04]
  wire logic hit_high   = hit_high_b || hit_high_d;
  wire logic hit_ier    = avs_address_i == uart_ctl_pkg::OFS_IRQ_ENABLES;
  wire logic hit_ident  = avs_address_i == uart_ctl_pkg::OFS_IDENT;
  wire logic hit_csr    = avs_address_i == uart_ctl_pkg::OFS_CLOCK_SELECT;
  // One-cycle wait: access completes on the second edge
  wire logic acc_go     = (avs_read_i || avs_write_i) && !rsp_valid;
  wire logic wr_do      = avs_write_i && rsp_valid;
  wire logic rd_do      = avs_read_i && rsp_valid;
  wire logic ident_rd   = rd_do && hit_ident;
  wire logic ier_wr     = wr_do && hit_ier;
  wire logic [7:0] wbyte = avs_writedata_i[7:0];

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !rsp_valid;
  assign avs_readdata_o    = rd_data;

  // Enable gating of each source
  wire logic en_rx   = irq_enables[uart_ctl_pkg::BIT_RX_DATA_EN];   // [R01]
  wire logic en_tx   = irq_enables[uart_ctl_pkg::BIT_TX_EMPTY_EN];  // [R01]
  wire logic en_line = irq_enables[uart_ctl_pkg::BIT_LINE_EN];      // [R01]
  wire logic en_mdm  = irq_enables[uart_ctl_pkg::BIT_MODEM_EN];     // [R01]

  // Raw sources; an all-zero enable quiets trigger and timeout
  wire logic line_req = rx_first_error_i && en_line;                 // [R09]
  wire logic trig_hit = rx_count_i >= rx_trigger_i;
  wire logic rx_req   = trig_hit && en_rx;                           // [R10][R15]
  wire logic to_req   = timeout_pend && en_rx;                       // [R11][R15]
  wire logic tx_req   = tx_empty_pend && en_tx;                      // [R13]
  wire logic mdm_req  = modem_delta_i && en_mdm;

  // Priority: line, rx/timeout, tx, modem
  wire logic [3:0] next_ident =
    line_req ? uart_ctl_pkg::ID_LINE :                               // [R20]
    rx_req   ? uart_ctl_pkg::ID_RX_DATA :
    to_req   ? uart_ctl_pkg::ID_TIMEOUT :
    tx_req   ? uart_ctl_pkg::ID_TX_EMPTY :
    mdm_req  ? uart_ctl_pkg::ID_MODEM : uart_ctl_pkg::ID_NONE;

  assign serial_irq_out_o = line_req || rx_req || to_req
                            || tx_req || mdm_req;                    // [R21]

  wire logic [31:0] rd_mux =
    hit_low   ? {24'h000000, divisor[7:0]} :
    hit_high  ? {24'h000000, divisor[15:8]} :
    hit_ier   ? {28'h0000000, irq_enables[3:0]} :
    hit_ident ? {24'h000000, uart_ctl_pkg::FIFO_ON_BITS & {2{fifo_enabled_i}},
                 2'h0, next_ident} :                                  // [R20]
    hit_csr   ? {30'h00000000, baud_source_field} : 32'h00000000;

  // Bus handshake and register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid         <= 1'b0;
      rd_data           <= 32'h00000000;
      irq_enables       <= uart_ctl_pkg::RST_IRQ_ENABLES;
      baud_source_field <= uart_ctl_pkg::RST_CLOCK_SELECT[1:0];
      divisor           <= uart_ctl_pkg::RST_DIVISOR;
    end else begin
      rsp_valid <= acc_go;
      if (acc_go && avs_read_i) begin
        rd_data <= rd_mux;
      end
      if (wr_do && hit_low) begin
        divisor[7:0] <= wbyte;                       // [R05]
      end
      if (wr_do && hit_high) begin
        divisor[15:8] <= wbyte;                      // [R05]
      end
      if (ier_wr) begin
        irq_enables <= {4'h0, wbyte[3:0]};
      end
      if (wr_do && hit_csr) begin
        baud_source_field <= wbyte[1:0];
      end
    end
  end

  // Ident holds its value between reads unless a write sets the tx-empty enable; snapshot taken on access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ident_id <= uart_ctl_pkg::ID_NONE;
    end else if (acc_go && avs_read_i && hit_ident) begin
      ident_id <= next_ident;                        // [R20]
    end else if (ier_wr && wbyte[1] && !en_tx) begin
      ident_id <= next_ident;                        // [R02] enable sets update
    end
  end

  // Timebase synchroniser and edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb_meta <= 1'b0;
      tb_sync <= 1'b0;
      tb_prev <= 1'b0;
      tb_div  <= 3'h0;
    end else begin
      tb_meta <= timebase_clock_i;
      tb_sync <= tb_meta;
      tb_prev <= tb_sync;
      if (tb_sync && !tb_prev) begin
        tb_div <= tb_div + 3'h1;
      end
    end
  end

  // Source select; a divided edge gives one tick
  wire logic tb_rise = tb_sync && !tb_prev;
  always_comb begin
    case (baud_source_field)                         // [R07]
      2'h0:    src_tick = 1'b1;
      2'h1:    src_tick = tb_rise && tb_div[0];
      2'h2:    src_tick = tb_rise && (tb_div[1:0] == 2'h3);
      2'h3:    src_tick = tb_rise && (tb_div == 3'h7);
      default: src_tick = 1'b0;
    endcase
  end

  // Divide by divisor; zero behaves as one so the tick never stalls
  wire logic baud_wrap = src_tick && (baud_cnt + 16'h0001 >= divisor);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_cnt    <= 16'h0000;
      baud_tick_o <= 1'b0;
      bit_phase   <= 4'h0;
      bit_tick    <= 1'b0;
    end else begin
      baud_tick_o <= baud_wrap;                      // [R06]
      bit_tick    <= baud_wrap && (bit_phase == 4'hF);
      if (baud_wrap) begin
        baud_cnt  <= 16'h0000;
        bit_phase <= bit_phase + 4'h1;               // [R06] 16 per bit
      end else if (src_tick) begin
        baud_cnt <= baud_cnt + 16'h0001;
      end
    end
  end

  // Frame length in bits, second stop bit included
  wire logic [4:0] frame_len = {1'b0, frame_bits_i}
                               + {4'h0, two_stop_bits_i};            // [R11]
  wire logic [7:0] timeout_bits = 8'(frame_len * uart_ctl_pkg::FRAMES_TIMEOUT);
  wire logic [7:0] tx_delay_bits = {3'h0, frame_len} - 8'h01;        // [R14]

  // Character timeout timer
  wire logic timer_rst = rx_pop_i || (rx_push_i && !timeout_pend);   // [R12]
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_bits    <= 8'h00;
      timeout_pend <= 1'b0;
    end else begin
      if (timer_rst || rx_count_i == ZERO_COUNT) begin
        idle_bits <= 8'h00;
      end else if (bit_tick && idle_bits != timeout_bits) begin
        idle_bits <= idle_bits + 8'h01;
      end
      if (rx_count_i != ZERO_COUNT && bit_tick
          && idle_bits + 8'h01 == timeout_bits) begin
        timeout_pend <= 1'b1;                        // [R11]
      end else if (rx_pop_i || rx_count_i == ZERO_COUNT) begin
        timeout_pend <= 1'b0;                        // [R12]
      end
    end
  end

  // Transmit-empty pending with delay after every drain, whatever the byte count
  wire logic tx_empty = tx_count_i == ZERO_COUNT;
  wire logic en_flip  = ier_wr && (wbyte[1] != en_tx);               // [R02]
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_empty_pend <= 1'b0;
      tx_empty_seen <= 1'b1;
      tx_delay_cnt  <= 8'h00;
    end else begin
      if (!tx_empty) begin
        tx_empty_seen <= 1'b0;
        tx_delay_cnt  <= 8'h00;
      end else if (!tx_empty_seen && bit_tick) begin
        tx_delay_cnt <= tx_delay_cnt + 8'h01;        // [R14]
        if (tx_delay_cnt + 8'h01 >= tx_delay_bits) begin
          tx_empty_seen <= 1'b1;
        end
      end
      if (tx_empty && !tx_empty_seen && bit_tick
          && tx_delay_cnt + 8'h01 >= tx_delay_bits) begin
        tx_empty_pend <= 1'b1;                       // [R13][R14]
      end else if (tx_empty && tx_empty_seen && en_flip) begin
        tx_empty_pend <= 1'b1;                       // [R02] re-raised
      end else if (tx_holding_write_i || !tx_empty
                   || (ident_rd && ident_id == uart_ctl_pkg::ID_TX_EMPTY)) begin
        tx_empty_pend <= 1'b0;                       // [R13]
      end
    end
  end

  // DMA requests
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_dma_request_o <= 1'b1;
      rx_dma_request_o <= 1'b0;
    end else begin
      if (!dma_mode_select_i) begin
        tx_dma_request_o <= tx_empty && !tx_holding_write_i;        // [R16]
      end else if (tx_empty) begin
        tx_dma_request_o <= 1'b1;                                   // [R17]
      end else if (tx_count_i >= FULL_COUNT) begin
        tx_dma_request_o <= 1'b0;                                   // [R17]
      end
      if (!dma_mode_select_i) begin
        rx_dma_request_o <= rx_count_i != ZERO_COUNT;               // [R18]
      end else if (rx_count_i == ZERO_COUNT) begin
        rx_dma_request_o <= 1'b0;                                   // [R19]
      end else if (trig_hit || timeout_pend) begin
        rx_dma_request_o <= 1'b1;                                   // [R19]
      end
    end
  end

  // Checks
  line_irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_first_error_i && en_line) |-> serial_irq_out_o) // [R09]
    else $error("line status not signalled");
  enable_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_enables[3:0] == 4'h0) |-> !serial_irq_out_o) // [R01]
    else $error("irq with all enables off");
  quiet_polled_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !en_rx |-> !(rx_req || to_req)) // [R15]
    else $error("rx irq while polled");
  rx_dma_m0_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !dma_mode_select_i ##1 !dma_mode_select_i
    |-> rx_dma_request_o == ($past(rx_count_i) != ZERO_COUNT)) // [R18]
    else $error("rx dma mode 0 wrong");
  rx_dma_empty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_count_i == ZERO_COUNT) |=> !rx_dma_request_o) // [R19]
    else $error("rx dma while empty");
  tx_dma_m0_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!dma_mode_select_i && tx_holding_write_i) |=> !tx_dma_request_o) // [R16]
    else $error("tx dma not dropped");
  tx_dma_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (dma_mode_select_i && tx_count_i >= FULL_COUNT) |=> !tx_dma_request_o)
    // [R17]
    else $error("tx dma while full");
  timeout_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_pop_i && !(bit_tick && idle_bits + 8'h01 == timeout_bits))
    |=> !timeout_pend) // [R12]
    else $error("timeout not cleared by read");
  tx_write_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tx_empty |=> !tx_empty_pend) // [R13]
    else $error("tx empty while data queued");
  bank_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_do && !divisor_access_bit_i
     && avs_address_i == uart_ctl_pkg::OFS_DIV_LOW_BANKED)
    |=> $stable(divisor)) // [R04]
    else $error("banked divisor written while locked");
  wait_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held two cycles");
  ident_prio_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (acc_go && avs_read_i && hit_ident && line_req)
    |=> ident_id == uart_ctl_pkg::ID_LINE) // [R20]
    else $error("line status not top priority");

  timeout_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(timeout_pend));
  tx_empty_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(tx_empty_pend));
  rx_dma_m1_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    dma_mode_select_i && $rose(rx_dma_request_o));
  ident_read_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    ident_rd && ident_id == uart_ctl_pkg::ID_TX_EMPTY);
endmodule : uart_irq_baud_dma_control
`default_nettype wire

// *** line_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module line_partner (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       send_i,
  input  wire logic       rx_pop_i,
  output logic      [4:0] rx_count_o,
  output logic            rx_push_o,
  output logic            timebase_clock_o
);
  logic [1:0] phase;
  wire        take = send_i && rx_count_o != 5'h10;
  wire        give = rx_pop_i && rx_count_o != 5'h00;
  // Free timebase at a quarter of the system rate, so edges stay countable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign timebase_clock_o = phase[1];
  // Bytes from the far end; a full FIFO drops them, as a real one would
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_count_o <= 5'h00;
      rx_push_o  <= 1'b0;
    end else begin
      rx_push_o  <= take;
      rx_count_o <= rx_count_o + {4'h0, take} - {4'h0, give};
    end
  end
endmodule : line_partner
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [23:0] avs_address_i = 24'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic avs_waitrequest_o, divisor_access_bit_i = 1'b0;
  logic dma_mode_select_i = 1'b0, fifo_enabled_i = 1'b0;
  logic two_stop_bits_i = 1'b0, rx_pop_i = 1'b0, rx_first_error_i = 1'b0;
  logic [3:0] frame_bits_i = 4'hA;
  logic [4:0] rx_trigger_i = 5'h04, tx_count_i = 5'h00, rx_count_i;
  logic line_state_read_i = 1'b0, tx_holding_write_i = 1'b0;
  logic modem_delta_i = 1'b0, send = 1'b0, rx_push_i, timebase_clock_i;
  logic baud_tick_o, serial_irq_out_o, tx_dma_request_o, rx_dma_request_o;
  int failures = 0, check_count = 0, seed = 5442, g, n;
  logic [7:0] d;
  always #4 clk_i = ~clk_i;
  uart_irq_baud_dma_control uart_irq_baud_dma_control_i (.clk_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .timebase_clock_i,
    .divisor_access_bit_i, .dma_mode_select_i, .fifo_enabled_i,
    .two_stop_bits_i, .frame_bits_i, .rx_count_i, .rx_trigger_i, .rx_push_i,
    .rx_pop_i, .rx_first_error_i, .line_state_read_i, .tx_count_i,
    .tx_holding_write_i, .modem_delta_i, .baud_tick_o, .serial_irq_out_o,
    .tx_dma_request_o, .rx_dma_request_o);
  line_partner line_partner_i (.clk_i, .rst_n_i, .send_i(send), .rx_pop_i,
    .rx_count_o(rx_count_i), .rx_push_o(rx_push_i),
    .timebase_clock_o(timebase_clock_i));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, exp, input string m);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h want %h", $time, m, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [23:0] a,
                     input logic [7:0] wd, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, wd};
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    k = 0;
    // Look between edges; the next rising edge then completes the access
    do begin
      @(negedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    q = avs_readdata_o;
    @(posedge clk_i);
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(negedge clk_i);
    if (k >= 50) begin failures++; conclude(); end
  endtask : bus
  task automatic wr(input logic [23:0] a, input logic [7:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask : wr
  task automatic rdc(input logic [23:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e, "read data");
  endtask : rdc
  // Pulses last one cycle with a quiet cycle after, never merging two
  task automatic push(input int k);
    repeat (k) begin
      @(posedge clk_i) send <= 1'b1;
      @(posedge clk_i) send <= 1'b0;
    end
    repeat (2) @(negedge clk_i);
  endtask : push
  task automatic pop(input int k);
    repeat (k) begin
      @(posedge clk_i) rx_pop_i <= 1'b1;
      @(posedge clk_i) rx_pop_i <= 1'b0;
    end
    repeat (2) @(negedge clk_i);
  endtask : pop
  task automatic wait_irq(input logic v, output int w);
    w = 0;
    while (serial_irq_out_o !== v && w < 3000) begin
      @(posedge clk_i);
      w++;
    end
    if (w >= 3000) begin failures++; conclude(); end
  endtask : wait_irq
  // Gap between baud ticks; the first gap after a change is discarded
  task automatic tick_gap(output int w);
    repeat (2) begin
      w = 0;
      do begin @(negedge clk_i); w++; end
      while (baud_tick_o !== 1'b1 && w < 5000);
    end
  endtask : tick_gap
  function automatic int gap_exp(input logic [1:0] s, input logic [7:0] v);
    return (s == 2'h0 ? 1 : 4 << s) * v;
  endfunction : gap_exp
  function automatic logic [31:0] id_exp(input logic [3:0] id);
    return {24'h0, fifo_enabled_i ? 2'h3 : 2'h0, 2'h0, id};
  endfunction : id_exp
  task automatic done(input string t);
    $display("test %s done", t);
  endtask : done
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdc(uart_ctl_pkg::OFS_IRQ_ENABLES, 32'(uart_ctl_pkg::RST_IRQ_ENABLES));
    rdc(uart_ctl_pkg::OFS_CLOCK_SELECT, 32'(uart_ctl_pkg::RST_CLOCK_SELECT));
    rdc(uart_ctl_pkg::OFS_IDENT, id_exp(uart_ctl_pkg::ID_NONE));
    done("reset");
    // Random register traffic, banked pair hidden until the access bit
    repeat (6) begin
      d = 8'($random(seed));
      wr(uart_ctl_pkg::OFS_DIV_LOW_DIRECT, d);
      wr(uart_ctl_pkg::OFS_DIV_HIGH_DIRECT, ~d);
      rdc(uart_ctl_pkg::OFS_DIV_LOW_BANKED, 32'h0);
      divisor_access_bit_i <= 1'b1;
      rdc(uart_ctl_pkg::OFS_DIV_LOW_BANKED, {24'h0, d});
      rdc(uart_ctl_pkg::OFS_DIV_HIGH_BANKED, {24'h0, ~d});
      wr(uart_ctl_pkg::OFS_DIV_HIGH_BANKED, d);
      divisor_access_bit_i <= 1'b0;
      rdc(uart_ctl_pkg::OFS_DIV_HIGH_DIRECT, {24'h0, d});
      wr(uart_ctl_pkg::OFS_IRQ_ENABLES, d & 8'hF0);
      rdc(uart_ctl_pkg::OFS_IRQ_ENABLES, 32'h0);
      wr(uart_ctl_pkg::OFS_CLOCK_SELECT, d);
      rdc(uart_ctl_pkg::OFS_CLOCK_SELECT, {30'h0, d[1:0]});
      rdc(24'h600318, 32'h0);
    end
    done("registers");
    for (int s = 0; s < 4; s++) begin
      d = {6'h0, 2'($random(seed))} + 8'h01;
      wr(uart_ctl_pkg::OFS_DIV_LOW_DIRECT, d);
      wr(uart_ctl_pkg::OFS_DIV_HIGH_DIRECT, 8'h00);
      wr(uart_ctl_pkg::OFS_CLOCK_SELECT, 8'(s));
      tick_gap(g);
      chk(32'(g), 32'(gap_exp(2'(s), d)), "baud gap");
    end
    wr(uart_ctl_pkg::OFS_DIV_LOW_DIRECT, 8'h01);
    wr(uart_ctl_pkg::OFS_CLOCK_SELECT, 8'h00);
    done("baud");
    fifo_enabled_i <= 1'b1;
    rx_first_error_i <= 1'b1;
    modem_delta_i <= 1'b1;
    wr(uart_ctl_pkg::OFS_IRQ_ENABLES, 8'h0C);
    chk(32'(serial_irq_out_o), 32'h1, "line irq");
    rdc(uart_ctl_pkg::OFS_IDENT, id_exp(uart_ctl_pkg::ID_LINE));
    @(posedge clk_i) rx_first_error_i <= 1'b0;
    line_state_read_i <= 1'b1;
    @(posedge clk_i) line_state_read_i <= 1'b0;
    rdc(uart_ctl_pkg::OFS_IDENT, id_exp(uart_ctl_pkg::ID_MODEM));
    wr(uart_ctl_pkg::OFS_IRQ_ENABLES, 8'h04);
    chk(32'(serial_irq_out_o), 32'h0, "masked irq");
    @(posedge clk_i) modem_delta_i <= 1'b0;
    done("line and modem");
    dma_mode_select_i <= 1'b1;
    wr(uart_ctl_pkg::OFS_IRQ_ENABLES, 8'h01);
    push(3);
    chk(32'(rx_dma_request_o), 32'h0, "rx dma below");
    chk(32'(serial_irq_out_o), 32'h0, "below trigger");
    push(1);
    chk(32'(rx_dma_request_o), 32'h1, "rx dma trig");
    rdc(uart_ctl_pkg::OFS_IDENT, id_exp(uart_ctl_pkg::ID_RX_DATA));
    pop(1);
    chk(32'(serial_irq_out_o), 32'h0, "drop below");
    chk(32'(rx_dma_request_o), 32'h1, "rx dma held");
    pop(3);
    @(posedge clk_i);
    chk(32'(rx_dma_request_o), 32'h0, "rx dma empty");
    dma_mode_select_i <= 1'b0;
    push(1);
    chk(32'(rx_dma_request_o), 32'h1, "rx dma any");
    wait_irq(1'b1, g);
    chk(32'(g > 540 && g < 730), 32'h1, "timeout span");
    rdc(uart_ctl_pkg::OFS_IDENT, id_exp(uart_ctl_pkg::ID_TIMEOUT));
    pop(1);
    chk(32'(serial_irq_out_o), 32'h0, "timeout clear");
    done("receive");
    @(posedge clk_i);
    chk(32'(tx_dma_request_o), 32'h1, "tx dma empty");
    tx_holding_write_i <= 1'b1;
    tx_count_i <= 5'h01;
    @(posedge clk_i) tx_holding_write_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(tx_dma_request_o), 32'h0, "tx dma first");
    wr(uart_ctl_pkg::OFS_IRQ_ENABLES, 8'h02);
    chk(32'(serial_irq_out_o), 32'h0, "no spurious");
    @(posedge clk_i) tx_count_i <= 5'h00;
    dma_mode_select_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(serial_irq_out_o), 32'h0, "tx delayed");
    chk(32'(tx_dma_request_o), 32'h1, "tx dma m1");
    wait_irq(1'b1, n);
    chk(32'(n > 125 && n < 165), 32'h1, "tx delay");
    rdc(uart_ctl_pkg::OFS_IDENT, id_exp(uart_ctl_pkg::ID_TX_EMPTY));
    repeat (2) @(posedge clk_i);
    chk(32'(serial_irq_out_o), 32'h0, "ident clear");
    wr(uart_ctl_pkg::OFS_IRQ_ENABLES, 8'h00);
    wr(uart_ctl_pkg::OFS_IRQ_ENABLES, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(32'(serial_irq_out_o), 32'h1, "re-raise");
    @(posedge clk_i) tx_holding_write_i <= 1'b1;
    tx_count_i <= 5'h08;
    @(posedge clk_i) tx_holding_write_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(serial_irq_out_o), 32'h0, "write clear");
    chk(32'(tx_dma_request_o), 32'h1, "tx dma part");
    @(posedge clk_i) tx_count_i <= 5'h10;
    repeat (3) @(posedge clk_i);
    chk(32'(tx_dma_request_o), 32'h0, "tx dma full");
    done("transmit");
    wr(uart_ctl_pkg::OFS_IRQ_ENABLES, 8'h00);
    push(5);
    repeat (2) @(posedge clk_i);
    chk(32'(serial_irq_out_o), 32'h0, "polled");
    chk(32'(rx_count_i), 32'h5, "still buffering");
    chk(32'(rx_dma_request_o), 32'h1, "rx dma polled");
    done("polled");
    conclude();
  end
endmodule : tb
`default_nettype wire
